/* core/dlos_cfg.svh */
`ifndef DLOS_CFG_SVH
`define DLOS_CFG_SVH
// What this block does
// - One read returns a snapshot of every line's present level.
// - Line 0 sits in the status word's lsb, higher lines above it.
// - Selected line's source setting picks the driving signal, only when output.
// - Source off disables the driver, pin floats.
// - User bit source follows the stored user register bit.
// - Acquisition-in-progress level is selectable.
// - Frame wait, trigger, lost trigger and capture levels are selectable.
// - Row wait, trigger, lost trigger and capture levels are selectable.
// - Exposure level, high during frame or row exposure, is selectable.
// - Each counter and timer offers a running level.
// - Each encoder output is selectable.
// - Each logic block and software signal output is selectable.
// - Each stream offers active, paused, stopping, stopped, overrun levels.
// - Each line holds a readable, writable electrical format setting.
// - Tri-state format means the line is not driven.
// - User bit index n addresses user register bit n from bit 0.
// - Single bit value write changes only the indexed bit; readable back.
// - Whole-word write updates all user bits, subject to mask.
// - Whole-word ones drive high, zeros drive low.
// - Whole-word lsb maps to user bit 0, upward in order.
// - Mask zero bits keep their user bits unchanged on whole-word write.
// - Mask ignored for single bit writes.
// - Lines come out of reset as inputs, undriven.
// - Reported status is taken after the polarity flip.

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define DLOS_OFF_LINE_SEL   8'h00
`define DLOS_OFF_LINE_CFG   8'h04
`define DLOS_OFF_LEVELS     8'h08
`define DLOS_OFF_UBIT_IDX   8'h0C
`define DLOS_OFF_UBIT_VAL   8'h10
`define DLOS_OFF_UBITS      8'h14
`define DLOS_OFF_UMASK      8'h18
// ------------------------------------------------------------
// Line configuration word fields
// ------------------------------------------------------------
`define DLOS_CFG_SRC_LSB    0
`define DLOS_CFG_DIR_BIT    8
`define DLOS_CFG_FLIP_BIT   9
`define DLOS_CFG_FMT_LSB    12
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DLOS_RST_SRC        6'h00
`define DLOS_RST_FMT        3'h2
`define DLOS_RST_UMASK      8'hFF
`endif

/* core/dlos_pkg.sv */
package dlos_pkg;
	typedef enum logic [2:0] {
		DLOS_FMT_NOCONN = 3'h0,
		DLOS_FMT_TRI    = 3'h1,
		DLOS_FMT_TTL    = 3'h2,
		DLOS_FMT_LVDS   = 3'h3,
		DLOS_FMT_RS422  = 3'h4,
		DLOS_FMT_OPTO   = 3'h5,
		DLOS_FMT_OD     = 3'h6
	} dlos_fmt_e;
	// Source codes: 0 off, 1..8 user bits, 9..21 acquisition states,
	// 22.. indexed units: 4 each of counters, timers, encoders, logic, sw,
	// then 5 stream states for each of 2 streams.
	typedef logic [5:0] dlos_src_t;
	typedef struct packed {
		logic       acq_trig_waiting;
		logic       acq_trig_recv;
		logic       acq_trig_lost;
		logic       acq_in_progress;
		logic       frame_trig_waiting;
		logic       frame_trig_recv;
		logic       frame_trig_lost;
		logic       frame_capture_on;
		logic       row_trig_waiting;
		logic       row_trig_recv;
		logic       row_trig_lost;
		logic       row_capture_on;
		logic       exposure_on;
		logic [3:0] counter_n_running;
		logic [3:0] timer_n_running;
		logic [3:0] encoder_n_out;
		logic [3:0] logic_n_out;
		logic [3:0] softsig_n_out;
		logic [1:0] stream_n_active;
		logic [1:0] stream_n_paused;
		logic [1:0] stream_n_stopping;
		logic [1:0] stream_n_stopped;
		logic [1:0] stream_n_overrun;
	} dlos_sources_s;
	typedef struct packed {
		logic      line_direction;
		logic      line_polarity_flip;
		dlos_fmt_e line_electrical_format;
		dlos_src_t line_drive_source;
	} dlos_line_cfg_s;
endpackage : dlos_pkg

/* core/dlos_top.sv */
// The Wishbone slave port and the address map are this design's own decisions.
`include "dlos_cfg.svh"
module dlos_top
	import dlos_pkg::*;
(
	input  wire logic          mclk_in,      // 100 MHz clock
	input  wire logic          reset_in,     // Synchronous, active high
	input  wire logic          wb_cyc_in,    // Wishbone cycle
	input  wire logic          wb_stb_in,    // Wishbone strobe
	input  wire logic          wb_we_in,     // Wishbone write enable
	input  wire logic [7:0]    wb_adr_in,    // Byte address
	input  wire logic [3:0]    wb_sel_in,    // Byte lanes
	input  wire logic [31:0]   wb_dat_in,    // Write data
	output logic      [31:0]   wb_dat_out,   // Read data
	output logic               wb_ack_out,   // Acknowledge
	input  wire dlos_sources_s src_in,       // Internal source levels
	input  wire logic [3:0]    line_pin_in,  // Pin level seen at pad
	output logic      [3:0]    line_pin_out, // Pin drive value
	output logic      [3:0]    line_oe_out   // Pin drive enable
);
	localparam int NL = 4;
	localparam int NU = 8;

	dlos_line_cfg_s cfg_q [NL];
	logic [1:0]     line_index_select_q;
	logic [2:0]     user_bit_index_q;
	logic [NU-1:0]  user_bits_q;
	logic [NU-1:0]  user_bits_write_mask_q;
	logic [NL-1:0]  pin_s1_q, pin_s2_q, pin_s3_q, pin_stable_q;
	logic [NL-1:0]  level_w;
	logic [NL-1:0]  drive_w;
	logic [NL-1:0]  en_w;
	logic           ack_q;
	logic [31:0]    rdat_q;
	logic           wr_w, rd_w;
	logic [63:0]    src_vec_w;

	assign wr_w = wb_cyc_in & wb_stb_in & wb_we_in & ~ack_q;
	assign rd_w = wb_cyc_in & wb_stb_in & ~wb_we_in & ~ack_q;

	// ------------------------------------------------------------
	// Source vector, indexed by the source code
	// ------------------------------------------------------------
	assign src_vec_w = {
		12'h000,
		src_in.stream_n_overrun, src_in.stream_n_stopped, src_in.stream_n_stopping,
		src_in.stream_n_paused, src_in.stream_n_active,
		src_in.softsig_n_out, src_in.logic_n_out,
		src_in.encoder_n_out,
		src_in.timer_n_running, src_in.counter_n_running,
		src_in.exposure_on,
		src_in.row_capture_on, src_in.row_trig_lost,
		src_in.row_trig_recv, src_in.row_trig_waiting,
		src_in.frame_capture_on, src_in.frame_trig_lost,
		src_in.frame_trig_recv, src_in.frame_trig_waiting,
		src_in.acq_in_progress, src_in.acq_trig_lost,
		src_in.acq_trig_recv, src_in.acq_trig_waiting,
		user_bits_q,
		1'b0
	};

	// ------------------------------------------------------------
	// Pin synchroniser and per-line drive
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		pin_s1_q <= line_pin_in;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pin_stable_q <= 4'h0;
		end else begin
			for (int i = 0; i < NL; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_stable_q[i] <= pin_s3_q[i];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NL; g++) begin : g_line
			logic raw_w;
			assign raw_w = src_vec_w[cfg_q[g].line_drive_source];
			// Output drive only in output direction, source not off, format neither tri nor no-connect
			assign en_w[g] = cfg_q[g].line_direction &
				(cfg_q[g].line_drive_source != `DLOS_RST_SRC) &
				(cfg_q[g].line_electrical_format != DLOS_FMT_TRI) &
				(cfg_q[g].line_electrical_format != DLOS_FMT_NOCONN);
			assign drive_w[g] = raw_w ^ cfg_q[g].line_polarity_flip;
			// Status after the polarity stage: outputs report the driven value
			assign level_w[g] = en_w[g] ? drive_w[g] :
				(pin_stable_q[g] ^ cfg_q[g].line_polarity_flip);
		end
	endgenerate

	// Drive values are registered so pins do not glitch with source decode
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			line_pin_out <= 4'h0;
			line_oe_out  <= 4'h0;
		end else begin
			line_pin_out <= drive_w;
			line_oe_out  <= en_w;
		end
	end

	// ------------------------------------------------------------
	// Per-line settings
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			line_index_select_q <= 2'h0;
		end else if (wr_w && wb_adr_in == `DLOS_OFF_LINE_SEL && wb_sel_in[0]) begin
			line_index_select_q <= wb_dat_in[1:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			for (int i = 0; i < NL; i++) begin
				cfg_q[i].line_direction         <= 1'b0;
				cfg_q[i].line_polarity_flip     <= 1'b0;
				cfg_q[i].line_electrical_format <= dlos_fmt_e'(`DLOS_RST_FMT);
				cfg_q[i].line_drive_source      <= `DLOS_RST_SRC;
			end
		end else if (wr_w && wb_adr_in == `DLOS_OFF_LINE_CFG) begin
			if (wb_sel_in[0]) begin
				cfg_q[line_index_select_q].line_drive_source <=
					wb_dat_in[`DLOS_CFG_SRC_LSB +: 6];
			end
			if (wb_sel_in[1]) begin
				cfg_q[line_index_select_q].line_direction <= wb_dat_in[`DLOS_CFG_DIR_BIT];
				cfg_q[line_index_select_q].line_polarity_flip <=
					wb_dat_in[`DLOS_CFG_FLIP_BIT];
				if (wb_dat_in[`DLOS_CFG_FMT_LSB +: 3] <= 3'h6) begin
					cfg_q[line_index_select_q].line_electrical_format <=
						dlos_fmt_e'(wb_dat_in[`DLOS_CFG_FMT_LSB +: 3]);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// User output register
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			user_bit_index_q <= 3'h0;
		end else if (wr_w && wb_adr_in == `DLOS_OFF_UBIT_IDX && wb_sel_in[0]) begin
			user_bit_index_q <= wb_dat_in[2:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			user_bits_write_mask_q <= `DLOS_RST_UMASK;
		end else if (wr_w && wb_adr_in == `DLOS_OFF_UMASK && wb_sel_in[0]) begin
			user_bits_write_mask_q <= wb_dat_in[NU-1:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			user_bits_q <= 8'h00;
		end else if (wr_w && wb_adr_in == `DLOS_OFF_UBIT_VAL && wb_sel_in[0]) begin
			user_bits_q[user_bit_index_q] <= wb_dat_in[0];
		end else if (wr_w && wb_adr_in == `DLOS_OFF_UBITS && wb_sel_in[0]) begin
			// Bit i of the word goes to user bit i, masked bits held
			user_bits_q <= (wb_dat_in[NU-1:0] & user_bits_write_mask_q) |
				(user_bits_q & ~user_bits_write_mask_q);
		end
	end

	// ------------------------------------------------------------
	// Wishbone read and acknowledge
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_in & wb_stb_in & ~ack_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			rdat_q <= 32'h0000_0000;
		end else if (rd_w) begin
			unique case (wb_adr_in)
				`DLOS_OFF_LINE_SEL: rdat_q <= {30'h0, line_index_select_q};
				`DLOS_OFF_LINE_CFG: rdat_q <= {17'h0,
					cfg_q[line_index_select_q].line_electrical_format, 2'h0,
					cfg_q[line_index_select_q].line_polarity_flip,
					cfg_q[line_index_select_q].line_direction, 2'h0,
					cfg_q[line_index_select_q].line_drive_source};
				`DLOS_OFF_LEVELS:   rdat_q <= {28'h0, level_w};
				`DLOS_OFF_UBIT_IDX: rdat_q <= {29'h0, user_bit_index_q};
				`DLOS_OFF_UBIT_VAL: rdat_q <= {31'h0, user_bits_q[user_bit_index_q]};
				`DLOS_OFF_UBITS:    rdat_q <= {24'h0, user_bits_q};
				`DLOS_OFF_UMASK:    rdat_q <= {24'h0, user_bits_write_mask_q};
				default:            rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdat_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_ubits_write;
		wr_w && wb_adr_in == `DLOS_OFF_UBITS && wb_sel_in[0];
	endsequence

	property p_oe_reset;
		@(posedge mclk_in) reset_in |=> line_oe_out == 4'h0;
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("line driven after reset");

	property p_off_undriven;
		@(posedge mclk_in) disable iff (reset_in)
		cfg_q[0].line_drive_source == `DLOS_RST_SRC |=> !line_oe_out[0];
	endproperty
	a_off_undriven: assert property (p_off_undriven) else $error("off line driven");

	property p_input_undriven;
		@(posedge mclk_in) disable iff (reset_in)
		!cfg_q[1].line_direction |=> !line_oe_out[1];
	endproperty
	a_input_undriven: assert property (p_input_undriven) else $error("input line driven");

	property p_tri_undriven;
		@(posedge mclk_in) disable iff (reset_in)
		cfg_q[1].line_electrical_format == DLOS_FMT_TRI |=> !line_oe_out[1];
	endproperty
	a_tri_undriven: assert property (p_tri_undriven) else $error("tri line driven");

	property p_masked_hold;
		@(posedge mclk_in) disable iff (reset_in)
		s_ubits_write |=> ((user_bits_q ^ $past(user_bits_q)) &
			~$past(user_bits_write_mask_q)) == 8'h00;
	endproperty
	a_masked_hold: assert property (p_masked_hold) else $error("masked user bit changed");

	property p_whole_write;
		@(posedge mclk_in) disable iff (reset_in)
		s_ubits_write |=> ((user_bits_q ^ $past(wb_dat_in[7:0])) &
			$past(user_bits_write_mask_q)) == 8'h00;
	endproperty
	a_whole_write: assert property (p_whole_write) else $error("user word not written");

	property p_single_write;
		@(posedge mclk_in) disable iff (reset_in)
		wr_w && wb_adr_in == `DLOS_OFF_UBIT_VAL && wb_sel_in[0] |=>
			user_bits_q[$past(user_bit_index_q)] == $past(wb_dat_in[0]) &&
			$countones(user_bits_q ^ $past(user_bits_q)) <= 1;
	endproperty
	a_single_write: assert property (p_single_write) else $error("single bit write wrong");

	property p_ack_one;
		@(posedge mclk_in) disable iff (reset_in)
		wb_ack_out |=> !wb_ack_out;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

	property p_drive_follow;
		@(posedge mclk_in) disable iff (reset_in)
		en_w[1] |=> line_oe_out[1] && line_pin_out[1] == $past(drive_w[1]);
	endproperty
	a_drive_follow: assert property (p_drive_follow) else $error("pin not following source");

	// ------------------------------------------------------------
	// Bus assertions
	// ------------------------------------------------------------
	sequence s_bus_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence

	property p_ack_answer;
		@(posedge mclk_in) disable iff (reset_in)
		s_bus_take |=> wb_ack_out;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

	property p_ack_cause;
		@(posedge mclk_in) disable iff (reset_in)
		wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

	property p_levels_read;
		@(posedge mclk_in) disable iff (reset_in)
		rd_w && wb_adr_in == `DLOS_OFF_LEVELS |=> wb_dat_out == {28'h0, $past(level_w)};
	endproperty
	a_levels_read: assert property (p_levels_read) else $error("level word not read");

	property p_unmapped_read;
		@(posedge mclk_in) disable iff (reset_in)
		rd_w && wb_adr_in > `DLOS_OFF_UMASK |=> wb_dat_out == 32'h0000_0000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_line_sel_write;
		@(posedge mclk_in) disable iff (reset_in)
		wr_w && wb_adr_in == `DLOS_OFF_LINE_SEL && wb_sel_in[0] |=>
			line_index_select_q == $past(wb_dat_in[1:0]);
	endproperty
	a_line_sel_write: assert property (p_line_sel_write) else $error("line index not set");

	// A write without byte lane 0 must not move the user bit index
	property p_lane_refused;
		@(posedge mclk_in) disable iff (reset_in)
		wr_w && wb_adr_in == `DLOS_OFF_UBIT_IDX && !wb_sel_in[0] |=> $stable(user_bit_index_q);
	endproperty
	a_lane_refused: assert property (p_lane_refused) else $error("lane 0 off write taken");

	// ------------------------------------------------------------
	// Per-line assertions
	// ------------------------------------------------------------
	generate
		for (g = 0; g < NL; g++) begin : g_line_chk
			property p_line_dir_off;
				@(posedge mclk_in) disable iff (reset_in)
				!cfg_q[g].line_direction |=> !line_oe_out[g];
			endproperty
			a_line_dir_off: assert property (p_line_dir_off) else $error("input line driven");

			property p_line_src_off;
				@(posedge mclk_in) disable iff (reset_in)
				cfg_q[g].line_drive_source == `DLOS_RST_SRC |=> !line_oe_out[g];
			endproperty
			a_line_src_off: assert property (p_line_src_off) else $error("off line driven");

			property p_line_fmt_off;
				@(posedge mclk_in) disable iff (reset_in)
				cfg_q[g].line_electrical_format inside {DLOS_FMT_TRI, DLOS_FMT_NOCONN} |=>
					!line_oe_out[g];
			endproperty
			a_line_fmt_off: assert property (p_line_fmt_off) else $error("tri line driven");

			property p_line_drive_on;
				@(posedge mclk_in) disable iff (reset_in)
				cfg_q[g].line_direction && cfg_q[g].line_drive_source != `DLOS_RST_SRC &&
					cfg_q[g].line_electrical_format == DLOS_FMT_TTL |=> line_oe_out[g];
			endproperty
			a_line_drive_on: assert property (p_line_drive_on) else $error("output not driven");

			property p_line_user_bit;
				@(posedge mclk_in) disable iff (reset_in)
				cfg_q[g].line_drive_source inside {[6'h01:6'h08]} |=> line_pin_out[g] ==
					$past(user_bits_q[3'(cfg_q[g].line_drive_source - 6'h01)] ^
					cfg_q[g].line_polarity_flip);
			endproperty
			a_line_user_bit: assert property (p_line_user_bit) else $error("user bit not on pin");

			// Pin changes count only once the last two stages agree
			property p_pin_hold;
				@(posedge mclk_in) disable iff (reset_in)
				pin_s2_q[g] != pin_s3_q[g] |=> $stable(pin_stable_q[g]);
			endproperty
			a_pin_hold: assert property (p_pin_hold) else $error("pin glitch accepted");

			property p_line_cfg_hold;
				@(posedge mclk_in) disable iff (reset_in)
				wr_w && wb_adr_in == `DLOS_OFF_LINE_CFG && line_index_select_q != 2'(g) |=>
					cfg_q[g] == $past(cfg_q[g]);
			endproperty
			a_line_cfg_hold: assert property (p_line_cfg_hold) else $error("other line changed");

			property p_fmt_refused;
				@(posedge mclk_in) disable iff (reset_in)
				wr_w && wb_adr_in == `DLOS_OFF_LINE_CFG && line_index_select_q == 2'(g) &&
					wb_sel_in[1] && wb_dat_in[`DLOS_CFG_FMT_LSB +: 3] == 3'h7 |=>
					$stable(cfg_q[g].line_electrical_format);
			endproperty
			a_fmt_refused: assert property (p_fmt_refused) else $error("format 7 taken");

			property p_line_reset;
				@(posedge mclk_in)
				reset_in |=> !cfg_q[g].line_direction &&
					cfg_q[g].line_drive_source == `DLOS_RST_SRC;
			endproperty
			a_line_reset: assert property (p_line_reset) else $error("line not input after reset");
		end
	endgenerate
endmodule : dlos_top

/* sim/dlos_pad_model.sv */
module dlos_pad_model (
	input  wire logic       clk_in,    // Device clock
	input  wire logic [3:0] oe_in,     // Device drive enable
	input  wire logic [3:0] drv_in,    // Device drive value
	input  wire logic [3:0] ext_en_in, // Far side drives the pad
	input  wire logic [3:0] ext_in,    // Far side drive value
	output logic      [3:0] pad_out    // Resolved pad level
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] float_q = 4'h0;

	// ------------------------------------------------------------
	// Pad resolution
	// ------------------------------------------------------------
	// An undriven pad wanders, so a stale level never passes for a drive
	always_ff @(posedge clk_in) begin
		float_q <= ~float_q;
	end

	assign pad_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
		| (~oe_in & ~ext_en_in & float_q);
endmodule : dlos_pad_model

/* sim/digital_line_output_select_tb.sv */
`include "dlos_cfg.svh"
module digital_line_output_select_tb
	import dlos_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int          SRCW    = $bits(dlos_sources_s);
	localparam logic [31:0] CFG_OUT = 32'h0000_2100;
	logic            mclk_in  = 1'b0;
	logic            reset_in = 1'b1;
	logic            cyc      = 1'b0;
	logic            stb      = 1'b0;
	logic            we       = 1'b0;
	logic [7:0]      adr      = 8'h00;
	logic [31:0]     wdat     = 32'h0;
	logic [3:0]      sel      = 4'h0;
	logic [3:0]      lanes    = 4'hF;
	logic [31:0]     rdat;
	logic [31:0]     dat_o;
	logic            ack;
	dlos_sources_s   src      = '0;
	logic [SRCW-1:0] oh;
	logic [3:0]      pad;
	logic [3:0]      pin_o;
	logic [3:0]      oe_o;
	logic [3:0]      ext_en   = 4'h0;
	logic [3:0]      ext_v    = 4'h0;
	int              n_mismatch      = 0;
	int              samples_checked = 0;
	int              cycles          = 0;

	always #5 mclk_in = ~mclk_in;

	dlos_top uut (
		.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(dat_o), .wb_ack_out(ack), .src_in(src), .line_pin_in(pad),
		.line_pin_out(pin_o), .line_oe_out(oe_o)
	);

	dlos_pad_model pads (
		.clk_in(mclk_in), .oe_in(oe_o), .drv_in(pin_o), .ext_en_in(ext_en),
		.ext_in(ext_v), .pad_out(pad)
	);

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Request held until ack is sampled high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		sel  <= lanes;
		adr  <= a;
		wdat <= d;
		do @(posedge mclk_in); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h0);
		check(what, rdat, exp);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : settle

	// Bit of the source struct that a source code routes
	function automatic int sbit(input int c);
		if (c <= 21) return 42 - (c - 9);
		if (c <= 41) return 26 - 4 * ((c - 22) / 4) + (c - 22) % 4;
		return 8 - 2 * ((c - 42) / 2) + (c - 42) % 2;
	endfunction : sbit

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		settle(20);
		reset_in <= 1'b0;
		settle(1);
		check("oe after reset", {28'h0, oe_o}, 32'h0);
		rd(`DLOS_OFF_LINE_CFG, 32'h0000_2000, "line cfg reset");
		rd(`DLOS_OFF_UMASK, 32'h0000_00FF, "mask reset");
		rd(8'h1C, 32'h0, "unmapped read");
		for (int f = 0; f < 7; f++) begin
			xfer(1'b1, `DLOS_OFF_LINE_CFG, 32'(f) << 12);
			rd(`DLOS_OFF_LINE_CFG, 32'(f) << 12, "format");
		end
		// Code 7 is not a format and must leave the setting alone
		xfer(1'b1, `DLOS_OFF_LINE_CFG, 32'h0000_7000);
		rd(`DLOS_OFF_LINE_CFG, 32'h0000_6000, "format 7");
		xfer(1'b1, `DLOS_OFF_UMASK, 32'h0);
		xfer(1'b1, `DLOS_OFF_UBIT_IDX, 32'h3);
		xfer(1'b1, `DLOS_OFF_UBIT_VAL, 32'h1);
		rd(`DLOS_OFF_UBIT_VAL, 32'h1, "bit value");
		rd(`DLOS_OFF_UBITS, 32'h08, "bit 3 only");
		xfer(1'b1, `DLOS_OFF_UMASK, 32'h0F);
		xfer(1'b1, `DLOS_OFF_UBITS, 32'hA5);
		rd(`DLOS_OFF_UBITS, 32'h05, "masked word");
		xfer(1'b1, `DLOS_OFF_UBIT_IDX, 32'h6);
		xfer(1'b1, `DLOS_OFF_UBIT_VAL, 32'h1);
		rd(`DLOS_OFF_UBITS, 32'h45, "bit past mask");
		lanes = 4'h2;
		xfer(1'b1, `DLOS_OFF_UBIT_IDX, 32'h1);
		lanes = 4'hF;
		rd(`DLOS_OFF_UBIT_IDX, 32'h6, "index lane 0 off");
		xfer(1'b1, `DLOS_OFF_UMASK, 32'hFF);
		xfer(1'b1, `DLOS_OFF_UBITS, 32'h3C);
		rd(`DLOS_OFF_UBITS, 32'h3C, "whole word");
		xfer(1'b1, `DLOS_OFF_LINE_SEL, 32'h1);
		rd(`DLOS_OFF_LINE_SEL, 32'h1, "line index");
		for (int b = 0; b < 8; b++) begin
			xfer(1'b1, `DLOS_OFF_LINE_CFG, CFG_OUT | 32'(b + 1));
			settle(3);
			check("user bit pin", {31'h0, pin_o[1]}, {31'h0, b >= 2 && b <= 5});
			check("user bit oe", {31'h0, oe_o[1]}, 32'h1);
		end
		xfer(1'b1, `DLOS_OFF_LINE_CFG, CFG_OUT | 32'h203);
		settle(3);
		check("flipped pin", {31'h0, pin_o[1]}, 32'h0);
		rd(`DLOS_OFF_LEVELS, 32'h0, "levels");
		check("flipped level", {31'h0, rdat[1]}, 32'h0);
		xfer(1'b1, `DLOS_OFF_LINE_CFG, CFG_OUT);
		settle(3);
		check("off oe", {31'h0, oe_o[1]}, 32'h0);
		xfer(1'b1, `DLOS_OFF_LINE_CFG, 32'h0000_1103);
		settle(3);
		check("tri oe", {31'h0, oe_o[1]}, 32'h0);
		xfer(1'b1, `DLOS_OFF_LINE_CFG, 32'h0000_2003);
		settle(3);
		check("input oe", {31'h0, oe_o[1]}, 32'h0);
		xfer(1'b1, `DLOS_OFF_LINE_SEL, 32'h2);
		for (int c = 9; c <= 51; c++) begin
			xfer(1'b1, `DLOS_OFF_LINE_CFG, CFG_OUT | 32'(c));
			oh = '0;
			oh[sbit(c)] = 1'b1;
			src <= oh;
			settle(3);
			check("source high", {31'h0, pin_o[2]}, 32'h1);
			src <= ~oh;
			settle(3);
			check("source low", {31'h0, pin_o[2]}, 32'h0);
		end
		xfer(1'b1, `DLOS_OFF_LINE_SEL, 32'h3);
		xfer(1'b1, `DLOS_OFF_LINE_CFG, 32'h0000_2200);
		ext_en <= 4'h8;
		ext_v  <= 4'h8;
		settle(6);
		rd(`DLOS_OFF_LEVELS, 32'h0, "levels");
		check("levels 3:2", {30'h0, rdat[3:2]}, 32'h0);
		ext_v <= 4'h0;
		settle(6);
		rd(`DLOS_OFF_LEVELS, 32'h8, "levels");
		check("levels 3:2", {30'h0, rdat[3:2]}, 32'h2);
		results();
	end
endmodule : digital_line_output_select_tb
